// ===== core/rx_status_pkg.sv
// Shared offsets, field positions and sizes of the receive port status group.
package rx_status_pkg;
    // Number of receive ports, each with its own copy of the group.
    localparam int PORT_COUNT = 4;
    // Width of the port index held in the port select register.
    localparam int PORT_IDX_W = 2;
    // Register offsets on the internal register access port.
    localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
    localparam logic [7:0] REMOTE_CSI_ERROR_FLAGS_ADDR = 8'h54;
    localparam logic [7:0] PARITY_ERROR_COUNT_HIGH_ADDR = 8'h55;
    localparam logic [7:0] PARITY_ERROR_COUNT_LOW_ADDR = 8'h56;
    localparam logic [7:0] SELF_TEST_ERROR_COUNT_ADDR = 8'h57;
    // Field positions of the remote CSI-2 flags.
    localparam int REMOTE_DOUBLE_ECC_BIT = 4;
    localparam int REMOTE_CHECKSUM_BIT = 3;
    localparam int REMOTE_START_OF_TRANSMISSION_BIT = 2;
    localparam int REMOTE_SYNC_BIT = 1;
    localparam int REMOTE_CONTROL_BIT = 0;
    localparam int REMOTE_FLAG_W = 5;
    // Field position of the port index inside the port select register.
    localparam int PORT_SELECT_LSB = 0;
    // Counter widths.
    localparam int PARITY_COUNT_W = 16;
    localparam int SELF_TEST_COUNT_W = 8;
    // Reset values.
    localparam logic [7:0] PORT_SELECT_RESET = 8'h00;
    localparam logic [REMOTE_FLAG_W-1:0] REMOTE_FLAGS_RESET = 5'h00;
    localparam logic [PARITY_COUNT_W-1:0] PARITY_COUNT_RESET = 16'h0000;
    localparam logic [SELF_TEST_COUNT_W-1:0] SELF_TEST_COUNT_RESET = 8'h00;
    // Saturation values of the counters.
    localparam logic [PARITY_COUNT_W-1:0] PARITY_COUNT_MAX = 16'hFFFF;
    localparam logic [SELF_TEST_COUNT_W-1:0] SELF_TEST_COUNT_MAX = 8'hFF;
endpackage : rx_status_pkg

// ===== core/rx_port_status.sv
// One receive port's copy of the remote flags, parity count and self-test count.
`timescale 1ns/1ps
`default_nettype none
module rx_port_status
    import rx_status_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic status_load,
    input wire logic [REMOTE_FLAG_W-1:0] status_in,
    input wire logic parity_error,
    input wire logic lock_new,
    input wire logic count_clear,
    input wire logic self_test_error,
    input wire logic self_test_clear,
    output logic [REMOTE_FLAG_W-1:0] flags_reg,
    output logic [PARITY_COUNT_W-1:0] parity_count_reg,
    output logic [SELF_TEST_COUNT_W-1:0] self_test_count_reg
);

    // Flags follow the forward channel only; the host has no write path here.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= REMOTE_FLAGS_RESET;
        end else if (status_load) begin
            flags_reg <= status_in;
        end
    end

    // Parity counter. A clear and an error in one cycle leave a count of one,
    // so that no error is lost to the clear. Saturates instead of wrapping.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            parity_count_reg <= PARITY_COUNT_RESET;
        end else if (lock_new || count_clear) begin
            // Both bytes restart together on new lock or low byte read.
            parity_count_reg <= parity_error ? 16'h0001 : PARITY_COUNT_RESET;
        end else if (parity_error && parity_count_reg != PARITY_COUNT_MAX) begin
            parity_count_reg <= parity_count_reg + 16'h0001;
        end
    end

    // Self-test error counter, restarted when a new self-test begins.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            self_test_count_reg <= SELF_TEST_COUNT_RESET;
        end else if (self_test_clear) begin
            self_test_count_reg <= self_test_error ? 8'h01 : SELF_TEST_COUNT_RESET;
        end else if (self_test_error && self_test_count_reg != SELF_TEST_COUNT_MAX) begin
            self_test_count_reg <= self_test_count_reg + 8'h01;
        end
    end

    // Flags take the loaded value one cycle after the load.
    flags_load_a: assert property (@(posedge clock) disable iff (!resetn)
        status_load |=> flags_reg == $past(status_in))
        else $error("flags did not take forward channel status");

    // A full counter stays full while errors keep coming.
    count_saturate_a: assert property (@(posedge clock) disable iff (!resetn)
        (parity_count_reg == PARITY_COUNT_MAX && parity_error && !lock_new && !count_clear)
        |=> parity_count_reg == PARITY_COUNT_MAX)
        else $error("parity counter wrapped");

    // Each lone error adds exactly one below saturation.
    count_step_a: assert property (@(posedge clock) disable iff (!resetn)
        (parity_error && !lock_new && !count_clear && parity_count_reg != PARITY_COUNT_MAX)
        |=> parity_count_reg == $past(parity_count_reg) + 16'h0001)
        else $error("parity counter missed an error");

    // New lock restarts the count.
    lock_restart_a: assert property (@(posedge clock) disable iff (!resetn)
        (lock_new && !parity_error) |=> parity_count_reg == PARITY_COUNT_RESET)
        else $error("parity counter not cleared on lock");

    // A lost-to-clear error would show as zero here.
    clear_keeps_a: assert property (@(posedge clock) disable iff (!resetn)
        (count_clear && parity_error) |=> parity_count_reg == 16'h0001)
        else $error("error lost in clear cycle");

    // Counter reaching saturation is a scenario worth seeing.
    count_full_c: cover property (@(posedge clock) disable iff (!resetn)
        parity_count_reg == PARITY_COUNT_MAX);

endmodule : rx_port_status
`default_nettype wire

// ===== core/rx_link_status_regs.sv
// Per-port status and error count registers behind the internal register port.
`timescale 1ns/1ps
`default_nettype none
module rx_link_status_regs
    import rx_status_pkg::*;
(
    // Core clock and asynchronous active-low reset.
    input wire logic clock,
    input wire logic resetn,
    // Internal register access port driven by the control interface.
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Forward channel status load, one strobe per port.
    input wire logic [PORT_COUNT-1:0] status_load,
    input wire logic [PORT_COUNT*REMOTE_FLAG_W-1:0] status_in,
    // Link receiver events, one pulse per port.
    input wire logic [PORT_COUNT-1:0] parity_error,
    input wire logic [PORT_COUNT-1:0] lock_new,
    // Self-test events, one pulse per port.
    input wire logic [PORT_COUNT-1:0] self_test_error,
    input wire logic [PORT_COUNT-1:0] self_test_clear,
    // Currently selected port, for the rest of the port-specific map.
    output logic [PORT_IDX_W-1:0] port_select
);

    // Port select register contents.
    logic [7:0] port_select_reg;
    // Per-port register copies gathered for the read mux.
    logic [REMOTE_FLAG_W-1:0] flags_all [PORT_COUNT];
    logic [PARITY_COUNT_W-1:0] parity_all [PORT_COUNT];
    logic [SELF_TEST_COUNT_W-1:0] self_test_all [PORT_COUNT];
    // Clear strobes for the parity counters, one per port.
    logic [PORT_COUNT-1:0] count_clear;
    // Read data before it is registered.
    logic [7:0] rdata_next;
    // Port index decoded from the select register.
    logic [PORT_IDX_W-1:0] sel;

    // The index field is the low bits of the select register.
    assign sel = port_select_reg[PORT_SELECT_LSB +: PORT_IDX_W];
    assign port_select = sel;

    // Port select register; writes are the only way the host moves between
    // copies, so every other register here is effectively keyed by it.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_select_reg <= PORT_SELECT_RESET;
        end else if (reg_write && reg_addr == PORT_SELECT_ADDR) begin
            port_select_reg <= reg_wdata;
        end
    end

    // A low byte read clears only the selected port's counter. The read data
    // is captured on the same edge, so the host still sees the old value.
    always_comb begin
        count_clear = '0;
        if (reg_read && reg_addr == PARITY_ERROR_COUNT_LOW_ADDR) begin
            count_clear[sel] = 1'b1;
        end
    end

    // One status copy per receive port.
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        rx_port_status u_port (
            .clock(clock),
            .resetn(resetn),
            .status_load(status_load[p]),
            .status_in(status_in[p*REMOTE_FLAG_W +: REMOTE_FLAG_W]),
            .parity_error(parity_error[p]),
            .lock_new(lock_new[p]),
            .count_clear(count_clear[p]),
            .self_test_error(self_test_error[p]),
            .self_test_clear(self_test_clear[p]),
            .flags_reg(flags_all[p]),
            .parity_count_reg(parity_all[p]),
            .self_test_count_reg(self_test_all[p])
        );
    end

    // Read mux. Unmapped offsets read as zero; writes to the read-only
    // registers fall through here with no effect at all.
    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr)
            PORT_SELECT_ADDR: begin
                rdata_next = port_select_reg;
            end
            REMOTE_CSI_ERROR_FLAGS_ADDR: begin
                // Reserved upper bits stay zero.
                rdata_next = {3'h0, flags_all[sel]};
            end
            PARITY_ERROR_COUNT_HIGH_ADDR: begin
                rdata_next = parity_all[sel][15:8];
            end
            PARITY_ERROR_COUNT_LOW_ADDR: begin
                rdata_next = parity_all[sel][7:0];
            end
            SELF_TEST_ERROR_COUNT_ADDR: begin
                rdata_next = self_test_all[sel];
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // Read data is held until the next read replaces it.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end
    end

    // Read valid is a one-cycle pulse the cycle after the request.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
        end
    end

    // Flags read returns the selected port's copy with reserved bits zero.
    flags_read_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == REMOTE_CSI_ERROR_FLAGS_ADDR)
        |=> reg_rvalid && reg_rdata[7:5] == 3'h0
            && reg_rdata[4:0] == $past(flags_all[sel]))
        else $error("flags read returned wrong data");

    // High byte read returns the upper half of the selected count.
    high_byte_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == PARITY_ERROR_COUNT_HIGH_ADDR)
        |=> reg_rdata == $past(parity_all[sel][15:8]))
        else $error("high byte read wrong");

    // Low byte read returns the old value and leaves a zero count behind.
    low_read_clear_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == PARITY_ERROR_COUNT_LOW_ADDR && !parity_error[sel])
        |=> reg_rdata == $past(parity_all[sel][7:0])
            && parity_all[$past(sel)] == PARITY_COUNT_RESET)
        else $error("low byte read did not return then clear");

    // A high byte read on its own does not touch the count.
    high_no_clear_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == PARITY_ERROR_COUNT_HIGH_ADDR
            && !parity_error[sel] && !lock_new[sel])
        |=> parity_all[$past(sel)] == $past(parity_all[sel]))
        else $error("high byte read cleared the count");

    // A low byte read on one port leaves the count of the neighbouring port (index sel ^ 1) alone.
    other_port_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == PARITY_ERROR_COUNT_LOW_ADDR
            && !parity_error[sel ^ 2'h1] && !lock_new[sel ^ 2'h1])
        |=> parity_all[$past(sel) ^ 2'h1] == $past(parity_all[sel ^ 2'h1]))
        else $error("low byte read cleared another port");

    // Host writes to the flags offset never change the flags.
    flags_no_write_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_write && reg_addr == REMOTE_CSI_ERROR_FLAGS_ADDR && !status_load[sel])
        |=> flags_all[$past(sel)] == $past(flags_all[sel]))
        else $error("host write changed remote flags");

    // Self-test count read returns the selected port's count.
    self_test_read_a: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == SELF_TEST_ERROR_COUNT_ADDR)
        |=> reg_rdata == $past(self_test_all[sel]))
        else $error("self-test count read wrong");

    // Valid stays low in the cycle after any cycle without a read request.
    rvalid_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
        (!reg_read) |=> !reg_rvalid)
        else $error("read valid without request");

    // Main scenarios: a nonzero count read and cleared, a port switch, flags seen.
    low_read_c: cover property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == PARITY_ERROR_COUNT_LOW_ADDR && parity_all[sel] != 16'h0000);
    port_switch_c: cover property (@(posedge clock) disable iff (!resetn)
        reg_write && reg_addr == PORT_SELECT_ADDR && reg_wdata[1:0] != sel);
    flags_seen_c: cover property (@(posedge clock) disable iff (!resetn)
        reg_read && reg_addr == REMOTE_CSI_ERROR_FLAGS_ADDR && flags_all[sel] != 5'h00);

endmodule : rx_link_status_regs
`default_nettype wire

// ===== verif/remote_serializer_model.sv
// Behavioural remote serializer driving forward-channel status and link parity events.
`timescale 1ns/1ps
`default_nettype none
module remote_serializer_model
    import rx_status_pkg::*;
(
    input wire logic clock,
    output logic [PORT_COUNT-1:0] status_load,
    output logic [PORT_COUNT*REMOTE_FLAG_W-1:0] status_in,
    output logic [PORT_COUNT-1:0] parity_error
);
    // Everything idles low at time zero.
    initial begin
        status_load = '0;
        status_in = '0;
        parity_error = '0;
    end

    // Sends one status frame to port p. Afterwards the lines carry the inverse value,
    // so a design that samples outside the load strobe picks up visibly wrong flags.
    task automatic send_status(input int p, input logic [REMOTE_FLAG_W-1:0] f);
        @(negedge clock);
        status_in[p*REMOTE_FLAG_W +: REMOTE_FLAG_W] = f;
        status_load[p] = 1'b1;
        @(negedge clock);
        status_load[p] = 1'b0;
        status_in = ~status_in;
    endtask : send_status

    // Raises the parity error line of port p for exactly n rising edges.
    task automatic send_parity(input int p, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            parity_error[p] = 1'b1;
        end
        @(negedge clock);
        parity_error[p] = 1'b0;
    endtask : send_parity
endmodule : remote_serializer_model
`default_nettype wire

// ===== verif/rx_link_status_regs_bench.sv
// Self-checking bench for the per-port status and error count registers.
`timescale 1ns/1ps
`default_nettype none
module rx_link_status_regs_bench;
    import rx_status_pkg::*;
    logic clock = 1'b0; // Core clock, 50 ns period.
    logic resetn = 1'b0; // Active-low reset, held for four cycles.
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [PORT_COUNT-1:0] lock_new = '0;
    logic [PORT_COUNT-1:0] self_test_error = '0;
    logic [PORT_COUNT-1:0] self_test_clear = '0;
    logic [PORT_COUNT-1:0] status_load;
    logic [PORT_COUNT*REMOTE_FLAG_W-1:0] status_in;
    logic [PORT_COUNT-1:0] parity_error;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [PORT_IDX_W-1:0] port_select;
    int n_errors = 0; // Mismatches seen.
    int checks = 0; // Comparisons made.
    // Per-port flag patterns; each port differs so a wrong copy shows up.
    logic [4:0] flag_tab [4] = '{5'h15, 5'h0A, 5'h1F, 5'h01};

    always #25 clock = ~clock;

    rx_link_status_regs i_dut (.clock(clock), .resetn(resetn), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .status_load(status_load),
        .status_in(status_in), .parity_error(parity_error), .lock_new(lock_new),
        .self_test_error(self_test_error), .self_test_clear(self_test_clear),
        .port_select(port_select));

    remote_serializer_model i_far (.clock(clock), .status_load(status_load),
        .status_in(status_in), .parity_error(parity_error));

    // Compares one byte; an unknown never matches because of case equality.
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8

    // One-cycle write strobe, driven between rising edges.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : reg_wr

    // One-cycle read strobe; the answer is fixed at one cycle, so it is looked at then.
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_read = 1'b0;
        check8({7'h00, reg_rvalid}, 8'h01, "read answer");
        check8(reg_rdata, exp, "read data");
    endtask : reg_rd

    // Picks a port and checks the select output follows.
    task automatic pick(input int p);
        reg_wr(PORT_SELECT_ADDR, 8'(p));
        check8({6'h00, port_select}, 8'(p), "port select");
    endtask : pick

    // Pulses one of the local event lines of port p for a single cycle.
    task automatic ev(input int kind, input int p);
        @(negedge clock);
        if (kind == 0) lock_new[p] = 1'b1;
        else if (kind == 1) self_test_error[p] = 1'b1;
        else self_test_clear[p] = 1'b1;
        @(negedge clock);
        lock_new = '0;
        self_test_error = '0;
        self_test_clear = '0;
    endtask : ev

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial begin
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        // Reset values, an unmapped place and a refused write to the flags.
        reg_rd(PORT_SELECT_ADDR, 8'h00);
        for (int a = 8'h54; a <= 8'h57; a++) reg_rd(8'(a), 8'h00);
        reg_rd(8'h60, 8'h00);
        reg_wr(REMOTE_CSI_ERROR_FLAGS_ADDR, 8'hFF);
        reg_rd(REMOTE_CSI_ERROR_FLAGS_ADDR, 8'h00);
        $display("test reset and refusals done");
        // Every port gets its own flags and parity count.
        for (int p = 0; p < PORT_COUNT; p++) begin
            i_far.send_status(p, flag_tab[p]);
            i_far.send_parity(p, p + 1);
        end
        for (int p = 0; p < PORT_COUNT; p++) begin
            pick(p);
            reg_rd(REMOTE_CSI_ERROR_FLAGS_ADDR, {3'h0, flag_tab[p]});
            reg_rd(PARITY_ERROR_COUNT_LOW_ADDR, 8'(p + 1));
        end
        $display("test per-port copies done");
        // Count split across bytes; high read alone keeps the value. Link idle first.
        i_far.send_parity(2, 291);
        pick(2);
        reg_rd(PARITY_ERROR_COUNT_HIGH_ADDR, 8'h01);
        reg_rd(PARITY_ERROR_COUNT_HIGH_ADDR, 8'h01);
        reg_rd(PARITY_ERROR_COUNT_LOW_ADDR, 8'h23);
        reg_rd(PARITY_ERROR_COUNT_HIGH_ADDR, 8'h00);
        reg_rd(PARITY_ERROR_COUNT_LOW_ADDR, 8'h00);
        $display("test byte split and read clear done");
        // A fresh lock restarts the count of its own port only.
        i_far.send_parity(1, 3);
        i_far.send_parity(2, 4);
        ev(0, 1);
        pick(1);
        reg_rd(PARITY_ERROR_COUNT_LOW_ADDR, 8'h00);
        pick(2);
        reg_rd(PARITY_ERROR_COUNT_LOW_ADDR, 8'h04);
        $display("test lock restart done");
        // Overflow past the top holds the all-ones value.
        i_far.send_parity(3, 65537);
        pick(3);
        reg_rd(PARITY_ERROR_COUNT_HIGH_ADDR, 8'hFF);
        reg_rd(PARITY_ERROR_COUNT_LOW_ADDR, 8'hFF);
        $display("test saturation done");
        // Self-test count rises per error and restarts on clear.
        for (int i = 0; i < 5; i++) ev(1, 0);
        pick(0);
        reg_rd(SELF_TEST_ERROR_COUNT_ADDR, 8'h05);
        reg_wr(SELF_TEST_ERROR_COUNT_ADDR, 8'h00);
        reg_rd(SELF_TEST_ERROR_COUNT_ADDR, 8'h05);
        ev(2, 0);
        reg_rd(SELF_TEST_ERROR_COUNT_ADDR, 8'h00);
        $display("test self-test count done");
        tally_and_finish();
    end

    // Cuts a hang short: the whole sequence needs well under this many cycles.
    initial begin
        for (int c = 0; c < 90000; c++) @(posedge clock);
        n_errors++;
        $display("[ERR] %0t run did not finish in time", $time);
        tally_and_finish();
    end
endmodule : rx_link_status_regs_bench
`default_nettype wire
